//--- hdl/wdt_defs.vh
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH

// register addresses on the internal bus
`define WDT_ADDR_TC_WR      32'hffff8610
`define WDT_ADDR_CSR_RD     32'hffff8610
`define WDT_ADDR_CNT_RD     32'hffff8611
`define WDT_ADDR_RST_WR     32'hffff8612
`define WDT_ADDR_RST_RD     32'hffff8613

// access size codes on bus_size
`define WDT_SIZE_BYTE       2'h0
`define WDT_SIZE_WORD       2'h1
`define WDT_SIZE_LONG       2'h2

// write keys in the upper byte of a word write
`define WDT_KEY_CNT         8'h5a
`define WDT_KEY_CSR         8'ha5
`define WDT_KEY_RST_CLR     8'ha5
`define WDT_KEY_RST_SET     8'h5a
`define WDT_RST_CLR_DATA    8'h00

// counter_control_status fields
`define WDT_CSR_OVF_BIT     7
`define WDT_CSR_ROLE_BIT    6
`define WDT_CSR_RUN_BIT     5
`define WDT_CSR_FILL        2'h3
`define WDT_CSR_RESET       8'h18

// overflow_reset_control fields
`define WDT_RST_WD_WRAP_FLAG_BIT    7
`define WDT_RST_WRAP_RESET_ENABLE_BIT    6
`define WDT_RST_WRAP_RESET_TYPE_BIT    5
`define WDT_RST_FILL        5'h1f
`define WDT_RST_RESET       8'h1f

// counter values
`define WDT_CNT_RESET       8'h00
`define WDT_CNT_TOP         8'hff

// pulse lengths in system clock cycles
`define WDT_WRAP_OUT_CYCLES 128
`define WDT_CHIP_RST_CYCLES 512

`endif

//--- hdl/wdt_prescaler.v
`timescale 1ns/10ps
`include "wdt_defs.vh"

// free-running divider of the system clock giving one tick per selected period
module wdt_prescaler #(
	parameter WIDTH = 13
) (
	input  wire             clk,
	input  wire             rst,
	input  wire             clr,
	input  wire [2:0]       sel,
	output wire             tick
);

	reg  [WIDTH-1:0] div_ff;
	wire [WIDTH-1:0] nxt_div;

	// mask of low bits that must all be one for the selected division
	function [WIDTH-1:0] div_mask;
		input [2:0] code;
		reg   [3:0] shift;
		begin
			case (code)
				3'h0: shift = 4'h1;
				3'h1: shift = 4'h6;
				3'h2: shift = 4'h7;
				3'h3: shift = 4'h8;
				3'h4: shift = 4'h9;
				3'h5: shift = 4'ha;
				3'h6: shift = 4'hc;
				3'h7: shift = 4'hd;
				default: shift = 4'h1;
			endcase
			div_mask = ~({WIDTH{1'b1}} << shift);
		end
	endfunction

	assign nxt_div = div_ff + {{(WIDTH-1){1'b0}}, 1'b1};
	assign tick    = ~clr & ((div_ff & div_mask(sel)) == div_mask(sel));

	// divider restarts from zero whenever counting is stopped
	always @(posedge clk) begin
		if (rst | clr) begin
			div_ff <= {WIDTH{1'b0}};
		end else begin
			div_ff <= nxt_div;
		end
	end

endmodule

//--- hdl/wdt_pulse.v
`timescale 1ns/10ps

// fixed-length output pulse; a new start restarts the length
module wdt_pulse #(
	parameter LEN        = 128,
	parameter ACTIVE_LOW = 0
) (
	input  wire clk,
	input  wire rst,
	input  wire start,
	output reg  pulse_ff
);

	localparam CW = 10;

	reg  [CW-1:0] left_ff;
	wire [CW-1:0] nxt_left;

	assign nxt_left = left_ff - {{(CW-1){1'b0}}, 1'b1};

	// count down the active cycles, idle level otherwise
	always @(posedge clk) begin
		if (rst) begin
			left_ff  <= {CW{1'b0}};
			pulse_ff <= (ACTIVE_LOW != 0);
		end else if (start) begin
			left_ff  <= LEN[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
			pulse_ff <= (ACTIVE_LOW == 0);
		end else if (left_ff != {CW{1'b0}}) begin
			left_ff  <= nxt_left;
			pulse_ff <= (ACTIVE_LOW == 0);
		end else begin
			pulse_ff <= (ACTIVE_LOW != 0);
		end
	end

endmodule

//--- hdl/watchdog_interval_timer.v
`timescale 1ns/10ps
`include "wdt_defs.vh"

// Operation
// - reset register loads 1f on pin reset, standby
// - watchdog wrap sets wd_wrap_flag, interval never
// - wd_wrap_flag clears after read one, zero write
// - enable clear: wrap resets counter, control only
// - reset type bit picks power-on or manual
// - counter, control written only by word writes
// - shared address, upper byte key selects target
// - reset register takes word writes only
// - key a5 data 00 clears wd_wrap_flag only
// - key 5a copies bits 6,5 to enable/type
// - byte reads at 8610, 8611, 8613
// - watchdog wrap drives wrap_out_n 128 cycles
// - enabled wrap gives 512-cycle chip reset
// - pin reset wins, wd_wrap_flag ends cleared
// - interval wrap sets flag and irq together
// - standby refused while count_run_enable set
// - nmi wake counts, wrap leaves standby
// - counter write beats a coinciding increment
// - counter increments while enabled or waking, cleared otherwise
// - divider codes give 2 to 8192
// - role select zero interval, one watchdog
// - interval flag clears read one, write zero
module watchdog_interval_timer #(
	parameter AW = 32
) (
	input  wire          clk,
	input  wire          rst,
	input  wire          ext_reset_n,
	input  wire [AW-1:0] bus_addr,
	input  wire          bus_wr,
	input  wire          bus_rd,
	input  wire [1:0]    bus_size,
	input  wire [15:0]   bus_wdata,
	output reg  [7:0]    bus_rdata_ff,
	input  wire          standby_req,
	input  wire          nmi_req,
	output reg           standby_ff,
	output reg           interval_irq_ff,
	output wire          wrap_out_n,
	output wire          chip_por_ff,
	output wire          chip_manual_ff
);

	// counter and control/status state
	reg [7:0] watch_counter_ff;
	reg       interval_wrap_flag_ff;
	reg       timer_role_select_ff;
	reg       count_run_enable_ff;
	reg [2:0] clock_divider_select_ff;
	reg       ovf_seen_ff;

	// reset control register state
	reg       wd_wrap_flag_ff;
	reg       wrap_reset_enable_ff;
	reg       wrap_reset_type_ff;
	reg       wd_wrap_flag_seen_ff;
	reg       waking_ff;

	// reset pin synchroniser
	reg       pin_s1_ff;
	reg       pin_s2_ff;
	reg       pin_s3_ff;
	reg       pin_rst_ff;

	// bus decode, event and read view nets
	wire [7:0] wr_lo;
	wire [7:0] wr_hi;
	wire       wr_word;
	wire       wr_cnt;
	wire       wr_csr;
	wire       wr_rst_clr;
	wire       wr_rst_set;
	wire       rd_byte;
	wire       tick;
	wire       counting;
	wire       inc;
	wire       wrap;
	wire       wd_wrap;
	wire       iv_wrap;
	wire       wake_done;
	wire       por;
	wire       chip_busy;
	wire       standby_enter;
	wire [7:0] csr_view;
	wire [7:0] rst_view;
	wire [7:0] nxt_counter;

	// three-stage pin sampling, level accepted when stages two and three agree
	always @(posedge clk) begin
		if (rst) begin
			pin_s1_ff  <= 1'b1;
			pin_s2_ff  <= 1'b1;
			pin_s3_ff  <= 1'b1;
			pin_rst_ff <= 1'b0;
		end else begin
			pin_s1_ff <= ext_reset_n;
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
			if (pin_s2_ff == pin_s3_ff) begin
				pin_rst_ff <= ~pin_s3_ff;
			end
		end
	end

	// the sampled pin acts as a power-on reset of the whole block
	assign por = rst | pin_rst_ff;

	// bus decode: writes count only as word writes with the right key
	assign wr_lo      = bus_wdata[7:0];
	assign wr_hi      = bus_wdata[15:8];
	assign wr_word    = bus_wr & (bus_size == `WDT_SIZE_WORD);
	assign wr_cnt     = wr_word & (bus_addr == `WDT_ADDR_TC_WR) & (wr_hi == `WDT_KEY_CNT);
	assign wr_csr     = wr_word & (bus_addr == `WDT_ADDR_TC_WR) & (wr_hi == `WDT_KEY_CSR);
	assign wr_rst_clr = wr_word & (bus_addr == `WDT_ADDR_RST_WR) & (wr_hi == `WDT_KEY_RST_CLR)
	                    & (wr_lo == `WDT_RST_CLR_DATA);
	assign wr_rst_set = wr_word & (bus_addr == `WDT_ADDR_RST_WR) & (wr_hi == `WDT_KEY_RST_SET);
	assign rd_byte    = bus_rd & (bus_size == `WDT_SIZE_BYTE);

	// counting and wrap events
	assign counting      = count_run_enable_ff | waking_ff;
	assign inc           = tick & counting & ~wr_cnt & ~chip_busy;
	assign wrap          = inc & (watch_counter_ff == `WDT_CNT_TOP);
	assign wd_wrap       = wrap & ~waking_ff & timer_role_select_ff;
	assign iv_wrap       = wrap & ~waking_ff & ~timer_role_select_ff;
	assign wake_done     = wrap & waking_ff;
	assign chip_busy     = chip_por_ff | chip_manual_ff;
	assign standby_enter = standby_req & ~standby_ff & ~count_run_enable_ff;
	assign nxt_counter   = watch_counter_ff + 8'h01;

	wdt_prescaler #(
		.WIDTH (13)
	) u_prescaler (
		.clk  (clk),
		.rst  (por),
		.clr  (~counting),
		.sel  (clock_divider_select_ff),
		.tick (tick)
	);

	// external overflow output, active low, idles high
	wdt_pulse #(
		.LEN        (`WDT_WRAP_OUT_CYCLES),
		.ACTIVE_LOW (1)
	) u_wrap_out (
		.clk      (clk),
		.rst      (por),
		.start    (wd_wrap),
		.pulse_ff (wrap_out_n)
	);

	// internal chip reset of power-on type
	wdt_pulse #(
		.LEN        (`WDT_CHIP_RST_CYCLES),
		.ACTIVE_LOW (0)
	) u_chip_por (
		.clk      (clk),
		.rst      (por),
		.start    (wd_wrap & wrap_reset_enable_ff & ~wrap_reset_type_ff),
		.pulse_ff (chip_por_ff)
	);

	// internal chip reset of manual type
	wdt_pulse #(
		.LEN        (`WDT_CHIP_RST_CYCLES),
		.ACTIVE_LOW (0)
	) u_chip_manual (
		.clk      (clk),
		.rst      (por),
		.start    (wd_wrap & wrap_reset_enable_ff & wrap_reset_type_ff),
		.pulse_ff (chip_manual_ff)
	);

	// counter: wdt-side reset on watchdog wrap, zero while stopped, write beats increment
	always @(posedge clk) begin
		if (por) begin
			watch_counter_ff <= `WDT_CNT_RESET;
		end else if (wd_wrap | chip_busy) begin
			watch_counter_ff <= `WDT_CNT_RESET;
		end else if (~counting) begin
			watch_counter_ff <= `WDT_CNT_RESET;
		end else if (wr_cnt) begin
			watch_counter_ff <= wr_lo;
		end else if (inc) begin
			watch_counter_ff <= nxt_counter;
		end
	end

	// control/status: mode, run, divider and the interval flag
	always @(posedge clk) begin
		if (por | wd_wrap | chip_busy) begin
			interval_wrap_flag_ff   <= 1'b0;
			timer_role_select_ff    <= 1'b0;
			count_run_enable_ff     <= 1'b0;
			clock_divider_select_ff <= 3'h0;
		end else if (standby_enter) begin
			interval_wrap_flag_ff <= 1'b0;
			timer_role_select_ff  <= 1'b0;
			count_run_enable_ff   <= 1'b0;
		end else begin
			if (iv_wrap) begin
				interval_wrap_flag_ff <= 1'b1;
			end else if (wr_csr & ~wr_lo[`WDT_CSR_OVF_BIT] & ovf_seen_ff) begin
				interval_wrap_flag_ff <= 1'b0;
			end
			if (wr_csr) begin
				timer_role_select_ff    <= wr_lo[`WDT_CSR_ROLE_BIT];
				count_run_enable_ff     <= wr_lo[`WDT_CSR_RUN_BIT];
				clock_divider_select_ff <= wr_lo[2:0];
			end
		end
	end

	// read-as-one tracking for the interval flag
	always @(posedge clk) begin
		if (por | wd_wrap | chip_busy | standby_enter) begin
			ovf_seen_ff <= 1'b0;
		end else if (wr_csr & ~wr_lo[`WDT_CSR_OVF_BIT]) begin
			ovf_seen_ff <= 1'b0;
		end else if (rd_byte & (bus_addr == `WDT_ADDR_CSR_RD) & interval_wrap_flag_ff) begin
			ovf_seen_ff <= 1'b1;
		end
	end

	// reset control register: kept across its own chip reset
	always @(posedge clk) begin
		if (por | standby_enter) begin
			wd_wrap_flag_ff      <= 1'b0;
			wrap_reset_enable_ff <= 1'b0;
			wrap_reset_type_ff   <= 1'b0;
			wd_wrap_flag_seen_ff         <= 1'b0;
		end else begin
			if (wd_wrap) begin
				wd_wrap_flag_ff <= 1'b1;
			end else if (wr_rst_clr & wd_wrap_flag_seen_ff) begin
				wd_wrap_flag_ff <= 1'b0;
			end
			if (wr_rst_clr) begin
				wd_wrap_flag_seen_ff <= 1'b0;
			end else if (rd_byte & (bus_addr == `WDT_ADDR_RST_RD) & wd_wrap_flag_ff) begin
				wd_wrap_flag_seen_ff <= 1'b1;
			end
			if (wr_rst_set) begin
				wrap_reset_enable_ff <= wr_lo[`WDT_RST_WRAP_RESET_ENABLE_BIT];
				wrap_reset_type_ff   <= wr_lo[`WDT_RST_WRAP_RESET_TYPE_BIT];
			end
		end
	end

	// standby entry, nmi wake and exit on counter wrap
	always @(posedge clk) begin
		if (por) begin
			standby_ff <= 1'b0;
			waking_ff  <= 1'b0;
		end else if (standby_enter) begin
			standby_ff <= 1'b1;
		end else if (wake_done) begin
			standby_ff <= 1'b0;
			waking_ff  <= 1'b0;
		end else if (standby_ff & nmi_req) begin
			waking_ff <= 1'b1;
		end
	end

	// interval interrupt pulse in the same cycle as the flag
	always @(posedge clk) begin
		if (por) begin
			interval_irq_ff <= 1'b0;
		end else begin
			interval_irq_ff <= iv_wrap;
		end
	end

	// register read views, reserved bits read as one
	assign csr_view = {interval_wrap_flag_ff, timer_role_select_ff, count_run_enable_ff,
	                   `WDT_CSR_FILL, clock_divider_select_ff};
	assign rst_view = {wd_wrap_flag_ff, wrap_reset_enable_ff, wrap_reset_type_ff, `WDT_RST_FILL};

	// byte read data, zero for other sizes and addresses
	always @(posedge clk) begin
		if (por) begin
			bus_rdata_ff <= 8'h00;
		end else if (rd_byte) begin
			case (bus_addr)
				`WDT_ADDR_CSR_RD: bus_rdata_ff <= csr_view;
				`WDT_ADDR_CNT_RD: bus_rdata_ff <= watch_counter_ff;
				`WDT_ADDR_RST_RD: bus_rdata_ff <= rst_view;
				default:          bus_rdata_ff <= 8'h00;
			endcase
		end else if (bus_rd) begin
			bus_rdata_ff <= 8'h00;
		end
	end

endmodule

//--- testbench/cpu_bus_model.sv
`timescale 1ns/10ps
`include "wdt_defs.vh"

// cpu side of the register bus, one strobe per access
module cpu_bus_model (
	input  wire        clk,
	output reg  [31:0] bus_addr = 32'h0,
	output reg         bus_wr = 1'b0,
	output reg         bus_rd = 1'b0,
	output reg  [1:0]  bus_size = 2'h0,
	output reg  [15:0] bus_wdata = 16'h0,
	input  wire [7:0]  bus_rdata_ff
);
	// keyed write held for its taking edge, then lines scrambled
	task wr(input [31:0] a, input [15:0] v, input [1:0] s);
		begin
			@(posedge clk);
			bus_addr <= a;
			bus_wdata <= v;
			bus_size <= s;
			bus_wr <= 1'b1;
			@(posedge clk);
			bus_wr <= 1'b0;
			bus_addr <= ~a;
			bus_wdata <= ~v;
		end
	endtask

	// byte read, data taken once the registered answer lands
	task rd(input [31:0] a, output [7:0] v);
		begin
			@(posedge clk);
			bus_addr <= a;
			bus_size <= `WDT_SIZE_BYTE;
			bus_rd <= 1'b1;
			@(posedge clk);
			bus_rd <= 1'b0;
			bus_addr <= ~a;
			#1 v = bus_rdata_ff;
		end
	endtask
endmodule

//--- testbench/watchdog_interval_timer_sva.sv
`timescale 1ns/10ps

// timing of overflow pulse, chip reset, irq and standby
module watchdog_interval_timer_sva (
	input wire clk,
	input wire rst,
	input wire standby_req,
	input wire standby_ff,
	input wire interval_irq_ff,
	input wire wrap_out_n,
	input wire chip_por_ff,
	input wire chip_manual_ff
);
	wire      chip_rst = chip_por_ff | chip_manual_ff;
	reg [9:0] lo_ff;
	reg [9:0] cr_ff;

	// length so far of the low pulse and of the chip reset
	always @(posedge clk) begin
		lo_ff <= (rst || wrap_out_n) ? 10'h0 : lo_ff + 10'h1;
		cr_ff <= (rst || !chip_rst) ? 10'h0 : cr_ff + 10'h1;
	end

	default clocking
		@(posedge clk);
	endclocking
	default disable iff (rst);

	chk_pulse_cap: assert property (lo_ff <= 10'h080)
		else $error("pulse too long");
	chk_pulse_len: assert property ($rose(wrap_out_n) && !$past(rst) |-> lo_ff == 10'h080)
		else $error("pulse not 128");
	chk_idle_high: assert property ($past(rst) |-> wrap_out_n)
		else $error("pin low after reset");
	chk_rst_cap: assert property (cr_ff <= 10'h200)
		else $error("chip reset too long");
	chk_rst_len: assert property ($fell(chip_rst) && !$past(rst) |-> cr_ff == 10'h200)
		else $error("chip reset not 512");
	chk_rst_start: assert property ($rose(chip_rst) |-> $fell(wrap_out_n))
		else $error("chip reset apart from pin");
	chk_one_type: assert property (!(chip_por_ff && chip_manual_ff))
		else $error("two reset types");
	chk_irq_single: assert property (interval_irq_ff |=> !interval_irq_ff)
		else $error("irq longer than one cycle");
	chk_irq_role: assert property (!(interval_irq_ff && $fell(wrap_out_n)))
		else $error("irq with pin pulse");
	chk_sleep_cause: assert property ($rose(standby_ff) |-> $past(standby_req))
		else $error("standby without request");

	cov_wd: cover property ($fell(wrap_out_n));
	cov_irq: cover property (interval_irq_ff);
	cov_manual: cover property ($rose(chip_manual_ff));
	cov_wake: cover property ($fell(standby_ff));
endmodule

bind watchdog_interval_timer watchdog_interval_timer_sva u_sva (
	.clk(clk), .rst(rst), .standby_req(standby_req), .standby_ff(standby_ff),
	.interval_irq_ff(interval_irq_ff), .wrap_out_n(wrap_out_n),
	.chip_por_ff(chip_por_ff), .chip_manual_ff(chip_manual_ff)
);

//--- testbench/watchdog_interval_timer_tb.sv
`timescale 1ns/10ps
`include "wdt_defs.vh"

module watchdog_interval_timer_tb;
	localparam [31:0] A_CSR = `WDT_ADDR_CSR_RD;
	localparam [31:0] A_CNT = `WDT_ADDR_CNT_RD;
	localparam [31:0] A_RST = `WDT_ADDR_RST_RD;
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg         ext_reset_n = 1'b1;
	reg         standby_req = 1'b0;
	reg         nmi_req = 1'b0;
	wire [31:0] bus_addr;
	wire        bus_wr;
	wire        bus_rd;
	wire [1:0]  bus_size;
	wire [15:0] bus_wdata;
	wire [7:0]  bus_rdata_ff;
	wire        standby_ff;
	wire        interval_irq_ff;
	wire        wrap_out_n;
	wire        chip_por_ff;
	wire        chip_manual_ff;
	wire [4:0]  mon = {chip_por_ff, standby_ff, interval_irq_ff, chip_manual_ff, wrap_out_n};
	reg  [7:0]  d;
	integer     n;
	integer     fail_count = 0;
	integer     samples_checked = 0;

	// 125 MHz system clock
	always #4 clk = ~clk;

	watchdog_interval_timer DUT (
		.clk             (clk),
		.rst             (rst),
		.ext_reset_n     (ext_reset_n),
		.bus_addr        (bus_addr),
		.bus_wr          (bus_wr),
		.bus_rd          (bus_rd),
		.bus_size        (bus_size),
		.bus_wdata       (bus_wdata),
		.bus_rdata_ff    (bus_rdata_ff),
		.standby_req     (standby_req),
		.nmi_req         (nmi_req),
		.standby_ff      (standby_ff),
		.interval_irq_ff (interval_irq_ff),
		.wrap_out_n      (wrap_out_n),
		.chip_por_ff     (chip_por_ff),
		.chip_manual_ff  (chip_manual_ff)
	);
	cpu_bus_model cpu (
		.clk          (clk),
		.bus_addr     (bus_addr),
		.bus_wr       (bus_wr),
		.bus_rd       (bus_rd),
		.bus_size     (bus_size),
		.bus_wdata    (bus_wdata),
		.bus_rdata_ff (bus_rdata_ff)
	);

	// compare one observed value with its expectation
	task check(input [31:0] seen, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask

	// byte read of one register and compare
	task rchk(input [31:0] a, input [7:0] e);
		begin
			cpu.rd(a, d);
			check({24'h0, d}, {24'h0, e});
		end
	endtask

	// keyed word writes to the timer address and the reset register
	task wtc(input [15:0] v);
		cpu.wr(`WDT_ADDR_TC_WR, v, `WDT_SIZE_WORD);
	endtask
	task wrs(input [15:0] v);
		cpu.wr(`WDT_ADDR_RST_WR, v, `WDT_SIZE_WORD);
	endtask

	// cycles a watched output keeps level v, capped at lim
	task span(input integer s, input v, input integer lim, output integer c);
		begin
			c = 0;
			while (mon[s] === v && c < lim) begin
				@(posedge clk);
				#1 c = c + 1;
			end
		end
	endtask

	// defaults after reset; byte writes ignored
	task t_reset;
		begin
			rchk(A_CSR, 8'h18);
			rchk(A_CNT, 8'h00);
			rchk(A_RST, 8'h1f);
			cpu.wr(`WDT_ADDR_TC_WR, 16'ha538, `WDT_SIZE_BYTE);
			cpu.wr(`WDT_ADDR_RST_WR, 16'h5a60, `WDT_SIZE_BYTE);
			rchk(A_CSR, 8'h18);
			rchk(A_RST, 8'h1f);
		end
	endtask

	// interval wrap sets flag and irq; flag clears by read then zero
	task t_interval;
		begin
			wtc(16'ha538);
			span(2, 1'b0, 600, n);
			check({31'h0, n > 505 && n < 515}, 32'h1);
			wtc(16'ha538);
			rchk(A_CSR, 8'hb8);
			rchk(A_RST, 8'h1f);
			wtc(16'ha5b8);
			rchk(A_CSR, 8'hb8);
			wtc(16'ha518);
			rchk(A_CSR, 8'h18);
		end
	endtask

	// watchdog wrap with reset disabled
	task t_watchdog;
		begin
			wtc(16'ha578);
			wtc(16'h5afc);
			span(0, 1'b1, 20, n);
			check({31'h0, n < 20}, 32'h1);
			span(0, 1'b0, 300, n);
			check(n, 32'h80);
			check({31'h0, chip_por_ff | chip_manual_ff}, 32'h0);
			wrs(16'ha500);
			rchk(A_RST, 8'h9f);
			rchk(A_CSR, 8'h18);
			wrs(16'ha500);
			rchk(A_RST, 8'h1f);
		end
	endtask

	// enabled wrap gives manual, then power-on chip reset; pin reset reloads register
	task t_chip_reset;
		begin
			wrs(16'h5a60);
			rchk(A_RST, 8'h7f);
			wtc(16'ha578);
			wtc(16'h5afc);
			span(1, 1'b0, 20, n);
			check({31'h0, chip_por_ff}, 32'h0);
			span(1, 1'b1, 600, n);
			check(n, 32'h200);
			rchk(A_RST, 8'hff);
			wrs(16'h5a40);
			rchk(A_RST, 8'hdf);
			wtc(16'ha578);
			wtc(16'h5afc);
			span(4, 1'b0, 20, n);
			check({31'h0, chip_manual_ff}, 32'h0);
			span(4, 1'b1, 600, n);
			check(n, 32'h200);
			@(posedge clk) ext_reset_n <= 1'b0;
			repeat (8) @(posedge clk);
			ext_reset_n <= 1'b1;
			repeat (8) @(posedge clk);
			rchk(A_RST, 8'h1f);
		end
	endtask

	// standby refused while counting; nmi wake ends it at the wrap
	task t_standby;
		begin
			wtc(16'ha538);
			@(posedge clk) standby_req <= 1'b1;
			repeat (3) @(posedge clk);
			standby_req <= 1'b0;
			#1 check({31'h0, standby_ff}, 32'h0);
			wtc(16'ha518);
			wrs(16'h5a60);
			@(posedge clk) standby_req <= 1'b1;
			@(posedge clk) standby_req <= 1'b0;
			#1 check({31'h0, standby_ff}, 32'h1);
			@(posedge clk) nmi_req <= 1'b1;
			@(posedge clk) nmi_req <= 1'b0;
			span(3, 1'b1, 600, n);
			check({31'h0, n > 500 && n < 520}, 32'h1);
			rchk(A_RST, 8'h1f);
		end
	endtask

	// verdict and end of run
	task give_verdict;
		begin
			if (fail_count == 0 && samples_checked > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask

	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_interval;
		t_watchdog;
		t_chip_reset;
		t_standby;
		give_verdict;
	end

	// watchdog, run needs about 2300 cycles
	initial begin
		#100000;
		fail_count = fail_count + 1;
		give_verdict;
	end
endmodule
